// File: design/epm_pkg.sv
// Shared constants and types of the parallel port mode control block.
package epm_pkg;
  // Clock period of the system clock in nanoseconds.
  localparam int CLK_NS = 8;
  // Strobe width and data setup of the compatibility handshake in nanoseconds.
  localparam int STB_NS = 500;
  // Strobe width in clock cycles, a least time rounded up.
  localparam int STB_CYC = (STB_NS + CLK_NS - 1) / CLK_NS;
  // Width of the strobe timer.
  localparam int TMR_W = 8;
  // Port offsets as seen on the host register port.
  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STAT = 11'h001;
  localparam logic [10:0] OFS_CTRL = 11'h002;
  localparam logic [10:0] OFS_FIFO = 11'h400;
  localparam logic [10:0] OFS_CFGB = 11'h401;
  localparam logic [10:0] OFS_XCTL = 11'h402;
  // Fixed value of configuration register A, an 8-bit implementation.
  localparam logic [7:0] CFGA_VAL = 8'h10;
  // Field positions of the extended port control register.
  localparam int XCTL_MODE_HI = 7;
  localparam int XCTL_MODE_LO = 5;
  localparam int XCTL_BITS_HI = 4;
  localparam int XCTL_BITS_LO = 2;
  // Reset value of the stored error-mask, DMA enable and service bits.
  localparam logic [2:0] XCTL_RST = 3'h5;
  // Field positions of the device control register.
  localparam int CTL_STB = 0;
  localparam int CTL_LFD = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SEL = 3;
  localparam int CTL_DIR = 5;
  localparam int CTL_W = 6;
  localparam logic [CTL_W-1:0] CTL_RST = 6'h00;
  // Unused low bits of the device status register.
  localparam int STAT_LOW_W = 3;
  // Byte width, tag bit of a queued command and run-length field width.
  localparam int BYTE_W = 8;
  localparam int CMD_BIT = 8;
  localparam int RUN_W = 7;
  // Number of synchronised pin inputs.
  localparam int SYNC_W = 13;
  // Interrupt line and DMA channel codes of configuration register B.
  localparam logic [2:0] IRQ_C15 = 3'h6;
  localparam logic [2:0] IRQ_C14 = 3'h5;
  localparam logic [2:0] IRQ_C11 = 3'h4;
  localparam logic [2:0] IRQ_C10 = 3'h3;
  localparam logic [2:0] IRQ_C9 = 3'h2;
  localparam logic [2:0] IRQ_C7 = 3'h1;
  localparam logic [2:0] IRQ_C5 = 3'h7;
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] DMA_C3 = 3'h3;
  localparam logic [2:0] DMA_C2 = 3'h2;
  localparam logic [2:0] DMA_C1 = 3'h1;
  // Port modes held in the mode field.
  typedef enum logic [2:0] {M_SPP = 3'b000, M_PS2 = 3'b001, M_PFIFO = 3'b010, M_ECP = 3'b011,
    M_EPP = 3'b100, M_RSVD = 3'b101, M_TEST = 3'b110, M_CFG = 3'b111} epm_mode_t;
  // States of the automatic link handshake.
  typedef enum logic [2:0] {L_IDLE = 3'b000, L_FSET = 3'b001, L_FSTB = 3'b010, L_FREL = 3'b011,
    L_RWAIT = 3'b100, L_RRLE = 3'b101, L_RACK = 3'b110} epm_link_t;
endpackage

// File: design/epm_fifo_if.sv
// Carrier of the queue signals between the port logic and its FIFO.
`timescale 1ns/1ns
interface epm_fifo_if #(parameter int W = 9);
  // Write strobe and word, read strobe, flush, head word and fill flags.
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic flush;
  logic [W-1:0] head;
  logic empty;
  logic full;
  modport ctl (output push, output wdata, output pop, output flush, input head, input empty, input full);
  modport mem (input push, input wdata, input pop, input flush, output head, output empty, output full);
endinterface

// File: design/epm_fifo.sv
// Byte queue with a registered head word and honest full and empty flags.
`timescale 1ns/1ns
module epm_fifo
  import epm_pkg::*;
#(
  parameter int W = 9,
  parameter int AW = 4
)
(
  input wire logic clk,
  input wire logic sys_rst,
  epm_fifo_if.mem f
);
  // Number of words held.
  localparam int DEPTH = 1 << AW;
  // Storage, pointers and fill count.
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [W-1:0] head_r;
  logic do_push;
  logic do_pop;
  logic [AW-1:0] rp_nxt;
  // A write to a full queue and a read of an empty one are ignored.
  assign do_push = f.push && !f.full;
  assign do_pop = f.pop && !f.empty;
  assign rp_nxt = rp_r + AW'(do_pop);
  assign f.empty = (cnt_r == '0);
  assign f.full = (cnt_r == (AW + 1)'(DEPTH));
  assign f.head = head_r;
  // The storage array takes the written word.
  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem_r[wp_r] <= f.wdata;
    end
  end
  // Pointers and count move with each accepted access; flush empties the queue.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else if (f.flush)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_r + AW'(do_push);
      rp_r <= rp_nxt;
      cnt_r <= cnt_r + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    end
  end
  // The head register bypasses a word written into an otherwise empty queue.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      head_r <= '0;
    end
    else if (f.flush)
    begin
      head_r <= '0;
    end
    else if (do_push && (cnt_r == (AW + 1)'(do_pop)))
    begin
      head_r <= f.wdata;
    end
    else
    begin
      head_r <= mem_r[rp_nxt];
    end
  end
endmodule

// File: design/epm_cfgb_enc.sv
// Encoder of the interrupt line and DMA channel fields of configuration register B.
`timescale 1ns/1ns
module epm_cfgb_enc
  import epm_pkg::*;
(
  input wire logic [3:0] irq_line,
  input wire logic [1:0] dma_chan,
  output logic [2:0] irq_code,
  output logic [2:0] dma_code
);
  always_comb
  begin
    unique case (irq_line)
      4'hF: irq_code = IRQ_C15;
      4'hE: irq_code = IRQ_C14;
      4'hB: irq_code = IRQ_C11;
      4'hA: irq_code = IRQ_C10;
      4'h9: irq_code = IRQ_C9;
      4'h7: irq_code = IRQ_C7;
      4'h5: irq_code = IRQ_C5;
      default: irq_code = SEL_NONE;
    endcase
  end
  always_comb
  begin
    unique case (dma_chan)
      2'h3: dma_code = DMA_C3;
      2'h2: dma_code = DMA_C2;
      2'h1: dma_code = DMA_C1;
      default: dma_code = SEL_NONE;
    endcase
  end
endmodule

// File: design/epm_port.sv
// Mode control and automatic link handshake of the extended parallel port.
`timescale 1ns/1ns
module epm_port
  import epm_pkg::*;
#(
  parameter int FIFO_AW = 4
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [10:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic enhanced_mode_option_cfg,
  input wire logic [3:0] irq_line_sel,
  input wire logic [1:0] dma_chan_sel,
  input wire logic irq_level,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic pd_oe,
  input wire logic busy_in,
  input wire logic ack_n_in,
  input wire logic fault_n_in,
  input wire logic select_in,
  input wire logic perror_in,
  output logic data_latch_pulse_n_o,
  output logic data_latch_pulse_n_oe,
  output logic line_feed_ctl_n_o,
  output logic line_feed_ctl_n_oe,
  output logic printer_reset_line_o,
  output logic printer_reset_line_oe,
  output logic printer_select_line_o,
  output logic printer_select_line_oe,
  output logic epp_active
);
  // True for the two programmed-I/O modes.
  function automatic logic is_base(input epm_mode_t m);
    is_base = (m == M_SPP) || (m == M_PS2);
  endfunction

  // Two-stage synchroniser for every pin input.
  logic [SYNC_W-1:0] sy1_r;
  logic [SYNC_W-1:0] sy2_r;
  // Synchronised pin levels.
  logic [7:0] pd_s;
  logic busy_s;
  logic ack_n_s;
  logic fault_n_s;
  logic select_s;
  logic perror_s;
  // Mode field, a deferred mode and its valid flag.
  epm_mode_t mode_r;
  epm_mode_t mode_pend_r;
  logic pend_v_r;
  // Stored error-mask, DMA enable and service bits.
  logic [2:0] xbits_r;
  // Device control bits and the data latch.
  logic [CTL_W-1:0] ctl_r;
  logic [7:0] dlatch_r;
  // Link state, strobe timer and byte being sent.
  epm_link_t link_r;
  logic [TMR_W-1:0] tmr_r;
  logic [CMD_BIT:0] tx_r;
  // Received byte, pending run count and repeats left.
  logic [7:0] rx_r;
  logic rle_v_r;
  logic [RUN_W-1:0] rle_cnt_r;
  logic [RUN_W-1:0] rep_r;
  // Registered pin drive.
  logic [3:0] cpin_r;
  logic [3:0] coe_r;
  logic [7:0] pd_out_r;
  logic pd_oe_r;
  logic [7:0] rdata_r;
  logic epp_r;
  // Decoded mode conditions and queue strobes.
  logic dir_eff;
  logic fwd_auto;
  logic rev_auto;
  logic host_push;
  logic host_pop;
  logic link_push;
  logic link_pop;
  logic cap_rev;
  logic [3:0] cpin_nxt;
  epm_mode_t wmode;
  logic [2:0] irq_code;
  logic [2:0] dma_code;

  // Queue between the host side and the link.
  epm_fifo_if #(.W(CMD_BIT + 1)) fq ();

  // Queue storage.
  epm_fifo #(.W(CMD_BIT + 1), .AW(FIFO_AW)) u_fifo
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .f(fq)
  );

  // Configuration register B field encoder.
  epm_cfgb_enc u_enc
  (
    .irq_line(irq_line_sel),
    .dma_chan(dma_chan_sel),
    .irq_code(irq_code),
    .dma_code(dma_code)
  );

  // Pins are caught twice before any logic looks at them.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sy1_r <= '0;
      sy2_r <= '0;
    end
    else
    begin
      sy1_r <= {pd_in, busy_in, ack_n_in, fault_n_in, select_in, perror_in};
      sy2_r <= sy1_r;
    end
  end
  assign {pd_s, busy_s, ack_n_s, fault_n_s, select_s, perror_s} = sy2_r;

  assign dir_eff = ctl_r[CTL_DIR] && (mode_r != M_SPP) && (mode_r != M_PFIFO);
  // handshake only in FIFO and ECP modes.
  assign fwd_auto = (mode_r == M_PFIFO) || ((mode_r == M_ECP) && !dir_eff);
  assign rev_auto = (mode_r == M_ECP) && dir_eff;
  assign wmode = epm_mode_t'(io_wdata[XCTL_MODE_HI:XCTL_MODE_LO]);

  // commands enter the queue only going forward.
  assign host_push = io_wr && (((io_addr == OFS_FIFO) && (fwd_auto || (mode_r == M_TEST)))
                     || ((io_addr == OFS_DATA) && (mode_r == M_ECP) && !dir_eff));
  // test mode reads the queue directly.
  assign host_pop = io_rd && (io_addr == OFS_FIFO) && (rev_auto || (mode_r == M_TEST));
  // A reverse byte is taken while the peripheral clocks it and room exists.
  assign cap_rev = (link_r == L_RWAIT) && !fq.full && !ack_n_s;
  // received data bytes are queued for the host.
  assign link_push = (cap_rev && busy_s) || ((link_r == L_RRLE) && !fq.full);
  assign link_pop = (link_r == L_IDLE) && fwd_auto && !fq.empty;

  // Queue strobes; host and link never write in the same direction.
  assign fq.push = host_push || link_push;
  assign fq.wdata = link_push ? {1'b0, ((link_r == L_RRLE) ? rx_r : pd_s)}
                    : {(io_addr == OFS_DATA), io_wdata};
  assign fq.pop = host_pop || link_pop;
  // queue held in reset in the programmed-I/O modes.
  // surplus reverse data is dropped on the way out.
  assign fq.flush = is_base(mode_r);

  // Mode field; a change from a forward mode to SPP or PS2 waits until the strobe is released.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_r <= M_SPP;
      mode_pend_r <= M_SPP;
      pend_v_r <= 1'b0;
    end
    else if (io_wr && (io_addr == OFS_XCTL))
    begin
      // defer the change while the strobe is low.
      if (is_base(wmode) && fwd_auto && (link_r == L_FSTB))
      begin
        mode_pend_r <= wmode;
        pend_v_r <= 1'b1;
      end
      else
      begin
        mode_r <= wmode;
        pend_v_r <= 1'b0;
      end
    end
    else if (pend_v_r && (link_r != L_FSTB))
    begin
      // the link is released forward before termination.
      mode_r <= mode_pend_r;
      pend_v_r <= 1'b0;
    end
  end

  // Stored control bits of the extended port control register.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      xbits_r <= XCTL_RST;
    end
    else if (io_wr && (io_addr == OFS_XCTL))
    begin
      xbits_r <= io_wdata[XCTL_BITS_HI:XCTL_BITS_LO];
    end
  end

  // Device control bits and the output data latch.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctl_r <= CTL_RST;
      dlatch_r <= '0;
    end
    else
    begin
      if (io_wr && (io_addr == OFS_CTRL))
      begin
        ctl_r <= io_wdata[CTL_W-1:0];
      end
      // In forward ECP mode this offset is the command queue instead.
      if (io_wr && (io_addr == OFS_DATA) && !((mode_r == M_ECP) && !dir_eff))
      begin
        dlatch_r <= io_wdata;
      end
    end
  end

  // Link handshake sequencer.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      link_r <= L_IDLE;
      tmr_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      rle_v_r <= 1'b0;
      rle_cnt_r <= '0;
      rep_r <= '0;
    end
    else if (!(fwd_auto || rev_auto))
    begin
      // reserved, test and other modes run no handshake.
      link_r <= L_IDLE;
      rle_v_r <= 1'b0;
    end
    else
    begin
      unique case (link_r)
        L_IDLE:
        begin
          if (link_pop)
          begin
            // next queued byte goes out in order.
            tx_r <= fq.head;
            tmr_r <= (mode_r == M_PFIFO) ? TMR_W'(STB_CYC) : '0;
            link_r <= L_FSET;
          end
          else if (rev_auto)
          begin
            link_r <= L_RWAIT;
          end
        end
        L_FSET:
        begin
          // Data setup; the compatibility handshake also waits for not busy.
          if (tmr_r != '0)
          begin
            tmr_r <= tmr_r - 1'b1;
          end
          else if ((mode_r != M_PFIFO) || !busy_s)
          begin
            tmr_r <= TMR_W'(STB_CYC);
            link_r <= L_FSTB;
          end
        end
        L_FSTB:
        begin
          // ECP ends the strobe on busy; compatibility on the timer.
          if (mode_r == M_PFIFO)
          begin
            if (tmr_r != '0)
            begin
              tmr_r <= tmr_r - 1'b1;
            end
            else
            begin
              link_r <= L_FREL;
            end
          end
          else if (busy_s)
          begin
            link_r <= L_FREL;
          end
        end
        L_FREL:
        begin
          if (!busy_s)
          begin
            link_r <= L_IDLE;
          end
        end
        L_RWAIT:
        begin
          // take each byte while the queue has room.
          if (cap_rev)
          begin
            rx_r <= pd_s;
            link_r <= L_RACK;
            if (!busy_s)
            begin
              // A command byte with a clear top bit is a run count.
              if (!pd_s[BYTE_W-1])
              begin
                rle_v_r <= 1'b1;
                rle_cnt_r <= pd_s[RUN_W-1:0];
              end
            end
            else if (rle_v_r)
            begin
              // repeat the data byte count more times.
              rle_v_r <= 1'b0;
              rep_r <= rle_cnt_r;
              if (rle_cnt_r != '0)
              begin
                link_r <= L_RRLE;
              end
            end
          end
        end
        L_RRLE:
        begin
          if (!fq.full)
          begin
            rep_r <= rep_r - 1'b1;
            if (rep_r == RUN_W'(1))
            begin
              link_r <= L_RACK;
            end
          end
        end
        L_RACK:
        begin
          if (ack_n_s)
          begin
            link_r <= L_IDLE;
          end
        end
        default:
        begin
          link_r <= L_IDLE;
        end
      endcase
    end
  end

  // Next levels of strobe, line feed, init and select lines.
  always_comb
  begin
    cpin_nxt[0] = fwd_auto ? (link_r != L_FSTB) : !ctl_r[CTL_STB];
    if ((mode_r == M_ECP) && !dir_eff)
    begin
      // line feed high for data, low for a command.
      cpin_nxt[1] = !tx_r[CMD_BIT];
    end
    else if (rev_auto)
    begin
      // Line feed low means ready; high acknowledges a held byte.
      cpin_nxt[1] = !(((link_r == L_RWAIT) && !fq.full) || (link_r == L_RRLE));
    end
    else
    begin
      cpin_nxt[1] = !ctl_r[CTL_LFD];
    end
    cpin_nxt[2] = ctl_r[CTL_INIT];
    cpin_nxt[3] = !ctl_r[CTL_SEL];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cpin_r <= '0;
      coe_r <= '0;
      pd_out_r <= '0;
      pd_oe_r <= 1'b0;
      epp_r <= 1'b0;
    end
    else
    begin
      // open collector drives only the low level.
      cpin_r <= (mode_r == M_SPP) ? '0 : cpin_nxt;
      coe_r <= (mode_r == M_SPP) ? ~cpin_nxt : '1;
      pd_out_r <= fwd_auto ? tx_r[BYTE_W-1:0] : dlatch_r;
      pd_oe_r <= !dir_eff;
      // EPP only with the option enabled.
      epp_r <= (mode_r == M_EPP) && enhanced_mode_option_cfg;
    end
  end

  // Read data register, loaded on each read strobe.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_r <= '0;
    end
    else if (io_rd)
    begin
      unique case (io_addr)
        // live pin levels while the port is input.
        OFS_DATA: rdata_r <= dir_eff ? pd_s : dlatch_r;
        OFS_STAT: rdata_r <= {!busy_s, ack_n_s, perror_s, select_s, fault_n_s, {STAT_LOW_W{1'b0}}};
        OFS_CTRL: rdata_r <= BYTE_W'(ctl_r);
        OFS_FIFO: rdata_r <= (mode_r == M_CFG) ? CFGA_VAL : fq.head[BYTE_W-1:0];
        OFS_CFGB: rdata_r <= (mode_r == M_CFG) ? {1'b0, irq_level, irq_code, dma_code} : '0;
        // empty and full flags track the queue.
        OFS_XCTL: rdata_r <= {mode_r, xbits_r, fq.full, fq.empty};
        default: rdata_r <= '0;
      endcase
    end
  end

  // Outputs.
  assign io_rdata = rdata_r;
  assign pd_out = pd_out_r;
  assign pd_oe = pd_oe_r;
  assign data_latch_pulse_n_o = cpin_r[0];
  assign data_latch_pulse_n_oe = coe_r[0];
  assign line_feed_ctl_n_o = cpin_r[1];
  assign line_feed_ctl_n_oe = coe_r[1];
  assign printer_reset_line_o = cpin_r[2];
  assign printer_reset_line_oe = coe_r[2];
  assign printer_select_line_o = cpin_r[3];
  assign printer_select_line_oe = coe_r[3];
  assign epp_active = epp_r;
endmodule

// File: bench/epm_port_sva.sv
// Port checker of the parallel port mode control block.
`timescale 1ns/1ns
module epm_port_sva
  import epm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [10:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic enhanced_mode_option_cfg,
  input wire logic [1:0] dma_chan_sel,
  input wire logic data_latch_pulse_n_o,
  input wire logic data_latch_pulse_n_oe,
  input wire logic epp_active
);
  // Mode last written by software, and reads of three offsets.
  logic [2:0] md_r;
  logic rx;
  logic rf;
  logic rb;
  assign rx = io_rd && io_addr == OFS_XCTL;
  assign rf = io_rd && io_addr == OFS_FIFO;
  assign rb = io_rd && io_addr == OFS_CFGB;
  // Follows every write of the mode field.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      md_r <= 3'h0;
    else if (io_wr && io_addr == OFS_XCTL)
      md_r <= io_wdata[7:5];
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Strobe falls on a driven line.
  sequence stb_fall;
    $fell(data_latch_pulse_n_o) && data_latch_pulse_n_oe;
  endsequence
  fifo_reset_a: assert property (rx && !data_latch_pulse_n_oe |=> io_rdata[1:0] == 2'h1)
    else $error("queue not held empty");
  stb_oc_a: assert property (!data_latch_pulse_n_oe |-> !data_latch_pulse_n_o)
    else $error("released strobe not open collector");
  cfga_read_a: assert property (rf && md_r == M_CFG |=> io_rdata == 8'h10)
    else $error("config A value wrong");
  cfgb_hide_a: assert property (rb && md_r != M_CFG |=> io_rdata == 8'h00)
    else $error("config B visible outside config mode");
  dma_code_a: assert property (rb && md_r == M_CFG |=> io_rdata[2:0] == {1'b0, $past(dma_chan_sel)})
    else $error("dma code wrong");
  stb_pulse_a: assert property (stb_fall |-> !data_latch_pulse_n_o [*2] ##[1:1000] data_latch_pulse_n_o)
    else $error("strobe pulse length wrong");
  rsvd_idle_a: assert property (md_r == M_RSVD |=> data_latch_pulse_n_o)
    else $error("strobe active in reserved mode");
  epp_on_a: assert property ($rose(epp_active) |-> $past(md_r) == M_EPP && $past(enhanced_mode_option_cfg))
    else $error("epp active without mode and option");
endmodule
bind epm_port epm_port_sva chk (.clk, .sys_rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
  .enhanced_mode_option_cfg, .dma_chan_sel, .data_latch_pulse_n_o, .data_latch_pulse_n_oe, .epp_active);

// File: bench/epm_periph_model.sv
// Behavioural peripheral on the far end of the parallel link.
`timescale 1ns/1ns
module epm_periph_model
(
  input wire logic stb_n,
  input wire logic lf_n,
  input wire logic [7:0] pd,
  input wire logic rev,
  input wire logic slow,
  output logic busy,
  output logic ack_n,
  output logic [7:0] mpd
);
  // Bytes taken with their line feed level, and bytes to send back.
  logic [8:0] got[$];
  logic [8:0] tx[$];
  int k = 0;
  initial
  begin
    busy = 1'b0;
    ack_n = 1'b1;
    mpd = 8'h5A;
  end
  // whole bytes
  // Takes a byte on each strobe fall and stays busy until strobe returns.
  always
  begin
    @(negedge stb_n);
    if (!rev)
    begin
      got.push_back({lf_n, pd});
      #(slow ? 400 : 3) busy = 1'b1;
      @(posedge stb_n);
      #(slow ? 400 : 3) busy = 1'b0;
    end
  end
  // command marking
  // Answers each ready with one byte; busy low marks a command.
  always
  begin
    wait (rev && !lf_n && k < tx.size());
    mpd = tx[k][7:0];
    busy = tx[k][8];
    #(slow ? 400 : 3) ack_n = 1'b0;
    wait (lf_n);
    #3 ack_n = 1'b1;
    mpd = ~mpd;
    k++;
  end
endmodule

// File: bench/epm_port_tb.sv
// Self-checking bench of the parallel port mode control block.
`timescale 1ns/1ns
module epm_port_tb
  import epm_pkg::*;
;
  logic clk = 0, sys_rst = 1, io_wr = 0, io_rd = 0, opt = 0, irq_level = 0, rev = 0, slow = 0;
  logic [10:0] io_addr = 0;
  logic [7:0] io_wdata = 0, io_rdata, pd_out, pd_in, mpd, v;
  logic [3:0] irq = 0;
  logic [1:0] dma_chan_sel = 0;
  logic pd_oe, stb_o, stb_oe, lf_o, lf_oe, busy, ack_n, epp_active;
  // Init and select line drive, watched against the control bits.
  logic init_o, init_oe, sel_o, sel_oe;
  int fails = 0, samples_checked = 0, i;
  always #4 clk = ~clk;
  // Released data lines show what the peripheral drives.
  assign pd_in = pd_oe ? pd_out : mpd;
  epm_port dut (.clk, .sys_rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .enhanced_mode_option_cfg(opt),
    .irq_line_sel(irq), .dma_chan_sel, .irq_level, .pd_in, .pd_out, .pd_oe, .busy_in(busy), .ack_n_in(ack_n),
    .fault_n_in(1'b1), .select_in(1'b1), .perror_in(1'b0), .data_latch_pulse_n_o(stb_o),
    .data_latch_pulse_n_oe(stb_oe), .line_feed_ctl_n_o(lf_o), .line_feed_ctl_n_oe(lf_oe),
    .printer_reset_line_o(init_o), .printer_reset_line_oe(init_oe), .printer_select_line_o(sel_o),
    .printer_select_line_oe(sel_oe), .epp_active);
  epm_periph_model m (.stb_n(stb_oe ? stb_o : 1'b1), .lf_n(lf_oe ? lf_o : 1'b1), .pd(pd_in), .rev, .slow,
    .busy, .ack_n, .mpd);
  task complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task ck(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1;
    @(negedge clk);
    io_wr = 0;
  endtask
  task rc(input logic [10:0] a, input logic [7:0] e);
    @(negedge clk);
    io_addr = a;
    io_rd = 1;
    @(negedge clk);
    io_rd = 0;
    ck(io_rdata, e);
  endtask
  // Writes a mode and keeps the stored control bits.
  task md(input logic [2:0] n);
    wr(OFS_XCTL, {n, 5'h14});
  endtask
  task tmo();
    if (i == 5000)
    begin
      fails++;
      complete_run();
    end
  endtask
  // Waits until n bytes went out and the link is idle again.
  task wt(input int n);
    for (i = 0; i < 5000 && (m.got.size() < n || busy || !stb_o); i++)
      @(negedge clk);
    tmo();
  endtask
  function logic [2:0] irqc(input logic [3:0] l);
    case (l)
      4'hF: irqc = 3'h6;
      4'hE: irqc = 3'h5;
      4'hB: irqc = 3'h4;
      4'hA: irqc = 3'h3;
      4'h9: irqc = 3'h2;
      4'h7: irqc = 3'h1;
      4'h5: irqc = 3'h7;
      default: irqc = 3'h0;
    endcase
  endfunction
  initial
  begin
    void'($urandom(32'h2073));
    repeat (12) @(negedge clk);
    sys_rst = 0;
    rc(OFS_XCTL, 8'h15);
    rc(11'h003, 8'h00);
    ck({7'h0, pd_oe}, 8'h01);
    ck({4'h0, init_o, init_oe, sel_o, sel_oe}, 8'h04);
    rc(OFS_CFGB, 8'h00);
    md(M_CFG);
    rc(OFS_FIFO, 8'h10);
    for (int j = 0; j < 16; j++)
    begin
      irq = 4'(j);
      dma_chan_sel = 2'($urandom);
      irq_level = 1'($urandom);
      rc(OFS_CFGB, {1'b0, irq_level, irqc(irq), 1'b0, dma_chan_sel});
    end
    md(M_PS2);
    wr(OFS_CTRL, 8'h20);
    repeat (4) @(negedge clk);
    ck({7'h0, pd_oe}, 8'h00);
    ck({4'h0, init_o, init_oe, sel_o, sel_oe}, 8'h07);
    rc(OFS_DATA, mpd);
    wr(OFS_CTRL, 8'h00);
    md(M_SPP);
    $display("end of config and direction test");
    md(M_TEST);
    for (int j = 0; j < 17; j++)
      wr(OFS_FIFO, 8'(j + 8'h30));
    rc(OFS_XCTL, 8'hD6);
    for (int j = 0; j < 16; j++)
      rc(OFS_FIFO, 8'(j + 8'h30));
    rc(OFS_XCTL, 8'hD5);
    ck(8'(m.got.size()), 8'h00);
    md(M_SPP);
    $display("end of test mode test");
    slow = 1;
    v = 8'($urandom);
    md(M_PFIFO);
    wr(OFS_FIFO, v);
    wr(OFS_FIFO, ~v);
    wt(2);
    ck(m.got[0][7:0], v);
    ck(m.got[1][7:0], ~v);
    md(M_SPP);
    slow = 0;
    m.got.delete();
    md(M_ECP);
    wr(OFS_DATA, v | 8'h80);
    wr(OFS_FIFO, v);
    wt(2);
    ck(m.got[0][7:0], v | 8'h80);
    ck({7'h0, m.got[0][8]}, 8'h00);
    ck(m.got[1][7:0], v);
    ck({7'h0, m.got[1][8]}, 8'h01);
    $display("end of forward test");
    md(M_PS2);
    wr(OFS_CTRL, 8'h20);
    rev = 1;
    m.tx = '{{1'b1, ~v}, 9'h002, {1'b1, v}};
    md(M_ECP);
    for (i = 0; i < 5000 && m.k < 3; i++)
      @(negedge clk);
    tmo();
    repeat (20) @(negedge clk);
    rc(OFS_FIFO, ~v);
    for (int j = 0; j < 3; j++)
      rc(OFS_FIFO, v);
    rc(OFS_XCTL, 8'h75);
    md(M_PS2);
    rev = 0;
    wr(OFS_CTRL, 8'h00);
    $display("end of reverse test");
    md(M_RSVD);
    wr(OFS_FIFO, v);
    rc(OFS_XCTL, 8'hB5);
    md(M_SPP);
    for (int j = 1; j >= 0; j--)
    begin
      opt = j[0];
      md(M_EPP);
      repeat (3) @(negedge clk);
      ck({7'h0, epp_active}, {7'h0, j[0]});
      md(M_SPP);
    end
    $display("end of reserved and epp test");
    complete_run();
  end
endmodule
